// [dv/ucpmc_dev_model.sv]
// Behavioural portable device attached to the data lines of the charge port.
`default_nettype none
module ucpmc_dev_model (
    // Clock.
    input  wire logic                 clk_i,
    // Data-line state presented by the port.
    input  wire ucpmc_pkg::ucpmc_dl_t dl_i,
    // Detection events reported to the controller.
    output logic                      attach_o,
    output logic                      release_o,
    output logic                      misclass_o,
    output logic                      connect_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ev;

    // ==========================================================
    // Event lines
    // Events rest low; each one is a single-cycle pulse launched after an edge.
    initial ev = 4'h0;
    assign attach_o   = ev[0];
    assign release_o  = ev[1];
    assign misclass_o = ev[2];
    assign connect_o  = ev[3];

    task automatic fire(input int idx);
        @(posedge clk_i);
        ev[idx] <= 1'b1;
        @(posedge clk_i);
        ev[idx] <= 1'b0;
    endtask : fire

    // Both probe steps find the lines tied, so the device decides it sits on a
    // dedicated port. It probes once divider bias is on the lines, or after 100 cycles at most.
    task automatic attach_compliant();
        int n = 0;
        while (dl_i.divider_bias_scheme !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        fire(0);
    endtask : attach_compliant

    // The device lets go of the data line after charging is agreed.
    task automatic release_line();
        fire(1);
    endtask : release_line

    // A non-compliant phone misreads the second probe step and does not connect until it sees a plain data port.
    task automatic misclassify();
        fire(2);
    endtask : misclassify

    // The phone enumerates once it sees a plain data port.
    task automatic connect();
        fire(3);
    endtask : connect
endmodule : ucpmc_dev_model
`default_nettype wire

// [dv/ucpmc_top_tb.sv]
// Self-checking bench of the charge-port mode controller.
`default_nettype none
module ucpmc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ucpmc_pkg::*;

    // ==========================================================
    // Signals
    logic        mclk, arst_n, en, oc, ot, wr, rd;
    logic        attach, rel, mis, conn;
    logic        pwr_sw, high_limit_setting, dchg, status_n, fault_n, cs_en;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    ucpmc_ctl_t  ctl;
    ucpmc_dl_t   dl;
    int          fail_count = 0;
    int          num_checks = 0;

    ucpmc_top i_ucpmc_top (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .CTL_I(ctl), .EN_I(en),
        .OVERCURRENT_I(oc), .OVERTEMP_I(ot), .BC_ATTACH_I(attach),
        .LINE_RELEASE_I(rel), .MISCLASS_I(mis), .DATA_CONNECT_I(conn),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .PWR_SW_O(pwr_sw), .HIGH_LIMIT_SETTING_SEL_O(high_limit_setting), .DISCHARGE_O(dchg),
        .STATUS_N_O(status_n), .FAULT_N_O(fault_n), .CS_EN_O(cs_en), .DL_O(dl)
    );

    ucpmc_dev_model i_ucpmc_dev_model (
        .clk_i(mclk), .dl_i(dl), .attach_o(attach), .release_o(rel),
        .misclass_o(mis), .connect_o(conn)
    );

    // Free-running 250 MHz clock.
    always #2 mclk = ~mclk;

    // ==========================================================
    // Helpers
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    // Counts the remaining discharge cycles; bounded so a stuck flag cannot hang.
    task automatic dchg_len();
        int n = 0;
        while (dchg === 1'b1 && n < 1000) begin
            @(posedge mclk) #1;
            n++;
        end
        check("dchg_len", (n + 1 >= DCHG_CYC) && (n < DCHG_CYC + 8), 1'b1);
    endtask : dchg_len

    task automatic chk_mode(input logic [2:0] c);
        logic cl, hi;
        cl = (c[2:1] == 2'b10);
        hi = (c == 3'h1) || (c == 3'h7);
        check("pwr", pwr_sw, !cl);
        check("ilim", high_limit_setting, hi);
        check("status", status_n, !hi);
        check("sense", cs_en, !cl);
        check("fault", fault_n, 1'b1);
        check("data", dl.data_switch, c[2:1] != 2'b00);
    endtask : chk_mode

    task automatic go(input logic [2:0] c, input logic ex);
        @(posedge mclk);
        ctl <= c;
        @(posedge mclk) #1;
        check("dchg", dchg, !ex);
        if (!ex) begin
            check("dchg_pwr", pwr_sw, 1'b0);
            check("dchg_data", dl.data_switch, 1'b0);
            dchg_len();
        end
        @(posedge mclk) #1;
        chk_mode(c);
    endtask : go

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] d;
        reg_rd(REG_CFG, d);
        check("cfg_rst", d, {30'h0, CFG_HOLD_RST, CFG_FB_RST});
        @(posedge mclk) #1;
        check("rdata_idle", rdata, 32'h0);
        reg_wr(8'h08, 32'hffff_ffff);
        reg_rd(8'h08, d);
        check("unmapped", d, 32'h0);
        reg_rd(REG_STAT, d);
        check("st_mode", d[ST_MODE_LSB +: 3], 3'h0);
    endtask : t_regs

    // Overcurrent must not open the data path; enable gates it in every mode.
    task automatic faults(input logic [2:0] c);
        logic d;
        d = dl.data_switch;
        @(posedge mclk);
        oc <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("oc_fault", fault_n, (c[2:1] == 2'b10) || c == 3'h0 || c == 3'h6);
        check("oc_data", dl.data_switch, d);
        @(posedge mclk);
        oc <= 1'b0;
        en <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check("en_low", dl.data_switch, 1'b0);
        @(posedge mclk);
        en <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("en_high", dl.data_switch, c[2:1] != 2'b00);
    endtask : faults

    // Walks every code; odd codes follow their even partner without discharge.
    task automatic t_walk();
        for (int i = 1; i <= 8; i++) begin
            go(3'(i), i[0]);
            faults(3'(i));
        end
        @(posedge mclk);
        ot <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("ot_fault", fault_n, 1'b0);
        @(posedge mclk);
        ot <= 1'b0;
    endtask : t_walk

    task automatic t_detect();
        int n = 0;
        logic [31:0] d;
        go(3'h1, 1'b1);
        check("div", dl, 4'b1000);
        i_ucpmc_dev_model.attach_compliant();
        #1;
        check("v12", dl, 4'b0110);
        check("v12_pwr", {pwr_sw, dchg}, 2'b10);
        while (dl.v12_pull === 1'b1 && n < 1200) begin
            @(posedge mclk) #1;
            n++;
        end
        check("v12_len", (n + 1 >= V12_CYC) && (n < V12_CYC + 8), 1'b1);
        check("short", dl, 4'b0010);
        check("short_pwr", {pwr_sw, dchg}, 2'b10);
        reg_rd(REG_STAT, d);
        check("st_det", d[ST_DET_LSB +: 2], 2'h2);
        i_ucpmc_dev_model.release_line();
        #1;
        check("back_div", dl, 4'b1000);
        repeat (50) @(posedge mclk);
        #1;
        check("div_stay", dl, 4'b1000);
    endtask : t_detect

    task automatic t_fallback();
        logic [31:0] d;
        go(3'h7, 1'b0);
        i_ucpmc_dev_model.misclassify();
        #1;
        check("fb_start", {dchg, status_n, high_limit_setting, dl.data_switch}, 4'b1100);
        dchg_len();
        check("fb_sdp", {dchg, status_n, high_limit_setting, dl.data_switch}, 4'b0101);
        reg_rd(REG_STAT, d);
        check("st_fb", d[ST_FB_BIT], 1'b1);
        i_ucpmc_dev_model.connect();
        #1;
        check("fb_back", {dchg, status_n, high_limit_setting, dl.data_switch}, 4'b0011);
        reg_wr(REG_CFG, 32'h3);
        @(posedge mclk) #1;
        check("hold", dl.data_switch, 1'b0);
        reg_wr(REG_CFG, 32'h0);
        i_ucpmc_dev_model.misclassify();
        repeat (2) @(posedge mclk);
        #1;
        check("fb_off", {dchg, status_n}, 2'b00);
    endtask : t_fallback

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        en = 1'b1;
        oc = 1'b0;
        ot = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        ctl = '0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (3) @(posedge mclk);
        #1;
        check("rst_out", {status_n, fault_n, pwr_sw, dchg, dl}, 8'hc0);
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("idle", {pwr_sw, high_limit_setting, status_n, dl}, 7'b1011000);
        t_regs();
        t_walk();
        t_detect();
        t_fallback();
        report_and_stop();
    end

    // The run needs about 4200 cycles; allow generous slack before giving up.
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        report_and_stop();
    end
endmodule : ucpmc_top_tb
`default_nettype wire

// [logic/ucpmc_pkg.sv]
// Shared constants, enumerations and carriers of the charge-port mode controller.
`default_nettype none
package ucpmc_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned DCHG_TIME_NS  = 2000;
    localparam int unsigned V12_TIME_NS   = 4000;
    localparam logic [15:0] DCHG_CYC =
        16'((DCHG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] V12_CYC  = 16'(V12_TIME_NS / CLK_PERIOD_NS);

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CFG      = 8'h00;
    localparam logic [7:0] REG_STAT     = 8'h04;
    localparam int unsigned CFG_FB_BIT   = 0;
    localparam int unsigned CFG_HOLD_BIT = 1;
    localparam logic       CFG_FB_RST   = 1'b1;
    localparam logic       CFG_HOLD_RST = 1'b0;
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_DET_LSB  = 4;
    localparam int unsigned ST_DCHG_BIT = 8;
    localparam int unsigned ST_FB_BIT   = 9;
    localparam int unsigned ST_CODE_LSB = 12;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        M_CHG_LO, M_CHG_AUTO, M_SDP, M_CLIENT, M_SDP_MASK, M_CDP
    } ucpmc_mode_t;

    typedef enum logic [1:0] {
        D_DIV, D_V12, D_SHORT
    } ucpmc_det_t;

    typedef struct packed {
        logic mode_select_pin_a;
        logic mode_select_pin_b;
        logic mode_select_pin_c;
    } ucpmc_ctl_t;

    typedef struct packed {
        logic divider_bias_scheme;
        logic v12_pull;
        logic short_lines;
        logic data_switch;
    } ucpmc_dl_t;
endpackage : ucpmc_pkg
`default_nettype wire

// [logic/ucpmc_timer.sv]
// One-shot cycle timer: busy while counting, one-cycle done pulse at the end.
`default_nettype none
module ucpmc_timer (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Control.
    input  wire logic        start_i,
    input  wire logic [15:0] len_i,
    // Status.
    output logic             busy_o,
    output logic             done_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        busy;
        logic        done;
    } ucpmc_tmr_t;

    ucpmc_tmr_t st_ff;
    ucpmc_tmr_t nxt_st;

    // A restart while busy reloads the count, so the last start always wins.
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (start_i) begin
            nxt_st.cnt  = len_i;
            nxt_st.busy = 1'b1;
        end else if (st_ff.busy) begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
            if (st_ff.cnt <= 16'h0001) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy_o = st_ff.busy;
    assign done_o = st_ff.done;
endmodule : ucpmc_timer
`default_nettype wire

// [logic/ucpmc_top.sv]
// Charge-port mode controller: pin decode, discharge sequencing and charge detection.
`default_nettype none
// Functional notes
// - Follow mode pins continuously, no trigger.
// - Decode the six modes from three pins.
// - No overcurrent fault in masked low modes.
// - Client: switch off, data through, outputs idle.
// - No discharge between 000 and 001.
// - No discharge between 110 and 111.
// - Code 111 falls back to data port.
// - Fallback discharges; return without discharge.
// - Data switches stay on during handshake; code runs detection only in charge-only modes, with data off.
// - Detection starts in divider bias.
// - Divider bias drives both lines high.
// - Compliant attach: switch on, brief pull.
// - Tie lines, pull, fixed time, then short.
// - Shorted mode ties lines through impedance.
// - Stay shorted until release, then divider.
// - Divider-accepting device keeps divider state.
// - Data on in data modes, enable high.
// - Data off on enable low or charging.
// - Current limit does not open data switches.
// - Data off throughout any discharge.
// - Low or high limit chosen per mode.
module ucpmc_top (
    // Clock and reset.
    input  wire logic              MCLK_I,
    input  wire logic              ARST_N_I,
    // Mode pins and enable.
    input  wire ucpmc_pkg::ucpmc_ctl_t CTL_I,
    input  wire logic              EN_I,
    // Analog monitors.
    input  wire logic              OVERCURRENT_I,
    input  wire logic              OVERTEMP_I,
    // Attached-device events.
    input  wire logic              BC_ATTACH_I,
    input  wire logic              LINE_RELEASE_I,
    input  wire logic              MISCLASS_I,
    input  wire logic              DATA_CONNECT_I,
    // Register port.
    input  wire logic [7:0]        ADDR_I,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic [31:0]            RDATA_O,
    // Power path.
    output logic                   PWR_SW_O,
    output logic                   HIGH_LIMIT_SETTING_SEL_O,
    output logic                   DISCHARGE_O,
    // Indicators.
    output logic                   STATUS_N_O,
    output logic                   FAULT_N_O,
    output logic                   CS_EN_O,
    // Data-line controls.
    output ucpmc_pkg::ucpmc_dl_t   DL_O
);
    import ucpmc_pkg::*;

    // ==========================================================
    // Decode helpers

    // Pin code to mode; 01x and 10x ignore the last pin.
    function automatic ucpmc_mode_t decode(input logic [2:0] c);
        ucpmc_mode_t m;
        m = M_CHG_LO;
        case (c)
            3'h0:    m = M_CHG_LO;
            3'h1:    m = M_CHG_AUTO;
            3'h2,
            3'h3:    m = M_SDP;
            3'h4,
            3'h5:    m = M_CLIENT;
            3'h6:    m = M_SDP_MASK;
            3'h7:    m = M_CDP;
            default: m = M_CHG_LO;
        endcase
        return m;
    endfunction : decode

    // Code pairs that swap without discharging the bus.
    function automatic logic exempt(input logic [2:0] a, input logic [2:0] b);
        return (a[2:1] == b[2:1]) && ((a[2:1] == 2'h0) || (a[2:1] == 2'h3));
    endfunction : exempt

    // Charge-only modes run the line detection and keep data off.
    function automatic logic chg_mode(input ucpmc_mode_t m);
        return (m == M_CHG_LO) || (m == M_CHG_AUTO);
    endfunction : chg_mode

    // ==========================================================
    // State

    typedef struct packed {
        ucpmc_mode_t mode;
        logic [2:0]  code;
        ucpmc_det_t  det;
        logic        fb;
        logic        fb_en;
        logic        hold;
        logic        dchg_go;
        logic        v12_go;
        logic        pwr;
        logic        high_limit_setting;
        logic        status_n;
        logic        fault_n;
        logic        cs;
        logic        dchg_o;
        ucpmc_dl_t   dl;
        logic [10:0] v12_age;
        logic [31:0] rdata;
    } ucpmc_st_t;

    ucpmc_st_t   st_ff;
    ucpmc_st_t   nxt_st;
    logic [2:0]  pin_code;
    ucpmc_mode_t pin_mode;
    logic        dchg_busy;
    logic        dchg_done;
    logic        v12_busy;
    logic        v12_done;
    logic        dchg;

    assign pin_code = {CTL_I.mode_select_pin_a, CTL_I.mode_select_pin_b,
                       CTL_I.mode_select_pin_c};
    assign pin_mode = decode(pin_code);
    // The start pulse covers the cycle before the timer reports busy.
    assign dchg     = dchg_busy | st_ff.dchg_go;

    // ==========================================================
    // Timers

    // Bus-output discharge length.
    ucpmc_timer u_dchg_tmr (
        .clk_i    (MCLK_I),
        .arst_n_i (ARST_N_I),
        .start_i  (st_ff.dchg_go),
        .len_i    (DCHG_CYC),
        .busy_o   (dchg_busy),
        .done_o   (dchg_done)
    );

    // Fixed dwell of the tied-and-pulled line state.
    ucpmc_timer u_v12_tmr (
        .clk_i    (MCLK_I),
        .arst_n_i (ARST_N_I),
        .start_i  (st_ff.v12_go),
        .len_i    (V12_CYC),
        .busy_o   (v12_busy),
        .done_o   (v12_done)
    );

    // ==========================================================
    // Next-state logic

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.dchg_go = 1'b0;
        nxt_st.v12_go  = 1'b0;

        // Mode tracking; the pins are watched every cycle.
        if (dchg || dchg_done) begin
            // Done follows the last busy cycle, so the new mode is taken on it.
            if (dchg_done) begin
                nxt_st.mode = pin_mode;
                nxt_st.code = pin_code;
            end
        end else if (pin_mode != st_ff.mode) begin
            if (exempt(st_ff.code, pin_code)) begin
                nxt_st.mode = pin_mode;
                nxt_st.code = pin_code;
            end else begin
                nxt_st.dchg_go = 1'b1;
            end
            nxt_st.fb = 1'b0;
        end else begin
            nxt_st.code = pin_code;
            // Fallback for devices that take the port as charge-only.
            if (st_ff.mode == M_CDP && st_ff.fb_en && !st_ff.fb && MISCLASS_I) begin
                nxt_st.fb      = 1'b1;
                nxt_st.dchg_go = 1'b1;
            end else if (st_ff.fb && DATA_CONNECT_I) begin
                nxt_st.fb = 1'b0;
            end
        end

        // Charge detection runs only in charge-only modes.
        if (!chg_mode(nxt_st.mode) || dchg) begin
            nxt_st.det = D_DIV;
        end else begin
            case (st_ff.det)
                D_DIV: begin
                    // A divider-accepting device never attaches here.
                    if (BC_ATTACH_I) begin
                        nxt_st.det    = D_V12;
                        nxt_st.v12_go = 1'b1;
                    end
                end
                D_V12: begin
                    if (v12_done) begin
                        nxt_st.det = D_SHORT;
                    end
                end
                D_SHORT: begin
                    if (LINE_RELEASE_I) begin
                        nxt_st.det = D_DIV;
                    end
                end
                default: nxt_st.det = D_DIV;
            endcase
        end

        // Register writes.
        if (WR_I && ADDR_I == REG_CFG) begin
            nxt_st.fb_en = WDATA_I[CFG_FB_BIT];
            nxt_st.hold  = WDATA_I[CFG_HOLD_BIT];
        end

        // Read data stands only in the cycle after the strobe.
        nxt_st.rdata = '0;
        if (RD_I) begin
            case (ADDR_I)
                REG_CFG: begin
                    nxt_st.rdata[CFG_FB_BIT]   = st_ff.fb_en;
                    nxt_st.rdata[CFG_HOLD_BIT] = st_ff.hold;
                end
                REG_STAT: begin
                    nxt_st.rdata[ST_MODE_LSB +: 3] = st_ff.mode;
                    nxt_st.rdata[ST_DET_LSB +: 2]  = st_ff.det;
                    nxt_st.rdata[ST_DCHG_BIT]      = dchg;
                    nxt_st.rdata[ST_FB_BIT]        = st_ff.fb;
                    nxt_st.rdata[ST_CODE_LSB +: 3] = st_ff.code;
                end
                default: nxt_st.rdata = '0;
            endcase
        end

        // Outputs follow the next state so that all ports leave flip-flops.
        // The switch stays on through detection steps; only discharge and
        // client mode turn it off.
        nxt_st.pwr = !nxt_st.dchg_go && !(dchg && !dchg_done) &&
                     (nxt_st.mode != M_CLIENT);
        nxt_st.dchg_o = nxt_st.dchg_go || (dchg && !dchg_done);
        nxt_st.high_limit_setting = (nxt_st.mode == M_CHG_AUTO) ||
                         (nxt_st.mode == M_CDP && !nxt_st.fb);
        nxt_st.status_n = !((nxt_st.mode == M_CHG_AUTO) ||
                            (nxt_st.mode == M_CDP && !nxt_st.fb));
        nxt_st.cs = (nxt_st.mode != M_CLIENT);
        // Overcurrent is masked in codes 000 and 110 and in client mode.
        if (nxt_st.mode == M_CLIENT) begin
            nxt_st.fault_n = 1'b1;
        end else if (nxt_st.mode == M_CHG_LO || nxt_st.mode == M_SDP_MASK) begin
            nxt_st.fault_n = !OVERTEMP_I;
        end else begin
            nxt_st.fault_n = !(OVERTEMP_I || OVERCURRENT_I);
        end
        // Data switches ignore the current limit on purpose.
        nxt_st.dl.data_switch = EN_I && !chg_mode(nxt_st.mode) &&
                                !nxt_st.dchg_o && !nxt_st.hold;
        nxt_st.dl.divider_bias_scheme = chg_mode(nxt_st.mode) && !nxt_st.dchg_o &&
                                        nxt_st.det == D_DIV;
        nxt_st.dl.v12_pull    = chg_mode(nxt_st.mode) && nxt_st.det == D_V12;
        nxt_st.dl.short_lines = chg_mode(nxt_st.mode) &&
                                (nxt_st.det != D_DIV);
        // Age of the pull state, kept only so the dwell check stays a counter.
        nxt_st.v12_age = st_ff.dl.v12_pull ? st_ff.v12_age + 11'h001 : 11'h000;
    end

    // ==========================================================
    // State register

    // Reset lands in the low-limit charge mode with the switch off.
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_ff          <= '0;
            st_ff.mode     <= M_CHG_LO;
            st_ff.det      <= D_DIV;
            st_ff.fb_en    <= CFG_FB_RST;
            st_ff.hold     <= CFG_HOLD_RST;
            st_ff.status_n <= 1'b1;
            st_ff.fault_n  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RDATA_O       = st_ff.rdata;
    assign PWR_SW_O      = st_ff.pwr;
    assign HIGH_LIMIT_SETTING_SEL_O = st_ff.high_limit_setting;
    assign DISCHARGE_O   = st_ff.dchg_o;
    assign STATUS_N_O    = st_ff.status_n;
    assign FAULT_N_O     = st_ff.fault_n;
    assign CS_EN_O       = st_ff.cs;
    assign DL_O          = st_ff.dl;

    // ==========================================================
    // Assertions

    localparam int DCHG_MAX = 510;
    localparam logic [10:0] V12_MAX = 11'h3f2;

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);

    AST_TRACK: assert property (
        (!dchg && !dchg_done && pin_mode != st_ff.mode && !exempt(st_ff.code, pin_code))
        |=> DISCHARGE_O)
        else $error("Non-exempt mode change did not start a discharge.");

    AST_DECODE: assert property (
        (!dchg && $stable(pin_code) && pin_code == 3'h7) |=> st_ff.mode == M_CDP)
        else $error("Code 111 did not select the charging data port.");

    AST_STATUS: assert property (
        !STATUS_N_O |-> (st_ff.mode == M_CHG_AUTO || st_ff.mode == M_CDP))
        else $error("Status asserted outside codes 001 and 111.");

    AST_FAULT_MASK: assert property (
        ($past(!OVERTEMP_I) && (st_ff.mode == M_CHG_LO || st_ff.mode == M_SDP_MASK))
        |-> FAULT_N_O)
        else $error("Overcurrent fault shown in a masked mode.");

    AST_CLIENT: assert property (
        st_ff.mode == M_CLIENT |-> (!PWR_SW_O && !CS_EN_O && FAULT_N_O))
        else $error("Client mode left power, sense or fault active.");

    AST_PAIR_LO: assert property (
        (st_ff.code == 3'h0 && !dchg && pin_code == 3'h1) |=> !DISCHARGE_O)
        else $error("Discharge between codes 000 and 001.");

    AST_PAIR_HI: assert property (
        (st_ff.code == 3'h6 && !dchg && pin_code == 3'h7) |=> !DISCHARGE_O)
        else $error("Discharge between codes 110 and 111.");

    AST_DCHG_LEN: assert property (
        $rose(DISCHARGE_O) |-> ##[1:DCHG_MAX] !DISCHARGE_O)
        else $error("Discharge lasted too long.");

    AST_DCHG_DATA: assert property (
        DISCHARGE_O |-> !DL_O.data_switch)
        else $error("Data switches on during discharge.");

    AST_EN_LOW: assert property (
        $past(!EN_I) |-> !DL_O.data_switch)
        else $error("Data switches on with enable low.");

    AST_V12_DWELL: assert property (
        st_ff.v12_age <= V12_MAX)
        else $error("Line pull state did not end in time.");

    AST_LIMIT: assert property (
        (st_ff.mode == M_CHG_LO || st_ff.mode == M_SDP) |-> !HIGH_LIMIT_SETTING_SEL_O)
        else $error("High limit in a low-limit mode.");
endmodule : ucpmc_top
`default_nettype wire
